// ==== dpc_pkg.sv ====
// Purpose: Shared constants and types for the DDR2 command decoder and power-state block
// Assumes: Single 40 MHz command clock, pins sampled synchronously
// Notes:   Timing figures are named here once and converted to cycles
`default_nettype none
package dpc_pkg;

	// ==========================================================
	// Geometry
	localparam int          BANKS       = 8;
	localparam int          BA_W        = 3;
	localparam int          ADDR_W      = 14;
	localparam int          ROW_W       = 14;
	localparam int          CNT_W       = 8;
	localparam int          A10_POS     = 10;

	// ==========================================================
	// Timing
	localparam int          CLK_PERIOD_PS = 25000;
	localparam int          TRP_PS        = 15000;
	localparam int          TRP_CYC       = (TRP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int          TRP_ALL_CYC   = TRP_CYC + 1;
	localparam int          TCKE_CYC      = 3;
	localparam int          TXP_CYC       = 2;
	localparam int          PRE_PRE_CYC   = 1;

	// ==========================================================
	// Decoded command set
	typedef enum logic [3:0] {
		DPC_CMD_DESEL  = 4'h0,
		DPC_CMD_NOP    = 4'h1,
		DPC_CMD_ACT    = 4'h2,
		DPC_CMD_READ   = 4'h3,
		DPC_CMD_WRITE  = 4'h4,
		DPC_CMD_PRE    = 4'h5,
		DPC_CMD_REF    = 4'h6,
		DPC_CMD_MRS    = 4'h7,
		DPC_CMD_ILL    = 4'h8
	} dpc_cmd_e;

	// Power states, Gray in listed order up -> PPD -> APD -> self -> exit
	typedef enum logic [2:0] {
		DPC_PW_UP      = 3'h0,
		DPC_PW_PPD     = 3'h1,
		DPC_PW_APD     = 3'h3,
		DPC_PW_SELF    = 3'h2,
		DPC_PW_EXIT    = 3'h6
	} dpc_pw_e;

	// Command pins as sampled on a rising edge
	typedef struct packed {
		logic              cke;
		logic              cs_n;
		logic              ras_n;
		logic              cas_n;
		logic              we_n;
		logic [BA_W-1:0]   ba;
		logic [ADDR_W-1:0] addr;
	} dpc_pins_s;

	// One decoded command, registered
	typedef struct packed {
		logic              valid;
		logic [3:0]        cmd;
		logic              auto_pre;
		logic              all_banks;
		logic [BA_W-1:0]   bank;
	} dpc_dec_s;

	// Decode the four strobes into a command
	function automatic dpc_cmd_e dpc_decode(input logic cs_n, input logic ras_n,
		input logic cas_n, input logic we_n);
		logic [2:0] s;
		s = {ras_n, cas_n, we_n};
		if (cs_n)
			return DPC_CMD_DESEL;
		case (s)
			3'h7:    return DPC_CMD_NOP;
			3'h3:    return DPC_CMD_ACT;
			3'h5:    return DPC_CMD_READ;
			3'h4:    return DPC_CMD_WRITE;
			3'h2:    return DPC_CMD_PRE;
			3'h1:    return DPC_CMD_REF;
			3'h0:    return DPC_CMD_MRS;
			default: return DPC_CMD_ILL;
		endcase
	endfunction

endpackage
`default_nettype wire

// ==== dpc_row_mem.sv ====
// Purpose: Small row memory holding the open row of each bank
// Assumes: One write port, one read port, read data registered
// Notes:   Read data appear one cycle after the address
`timescale 1ns/1ps
`default_nettype none
module dpc_row_mem (
	input  wire logic                         core_clk_i,
	input  wire logic                         wr_en_i,
	input  wire logic [dpc_pkg::BA_W-1:0]     wr_bank_i,
	input  wire logic [dpc_pkg::ROW_W-1:0]    wr_row_i,
	input  wire logic [dpc_pkg::BA_W-1:0]     rd_bank_i,
	output logic      [dpc_pkg::ROW_W-1:0]    rd_row_o
);

	// ==========================================================
	// Storage
	logic [dpc_pkg::ROW_W-1:0] mem_reg [dpc_pkg::BANKS];

	// Write port
	always_ff @(posedge core_clk_i) begin
		if (wr_en_i)
			mem_reg[wr_bank_i] <= wr_row_i;
	end

	// Registered read port
	always_ff @(posedge core_clk_i) begin
		rd_row_o <= mem_reg[rd_bank_i];
	end

endmodule // dpc_row_mem
`default_nettype wire

// ==== dpc_cmd_core.sv ====
// Purpose: Device-side DDR2 command decode, bank state, refresh and power-down
// Assumes: Controller keeps all spacing rules; pins valid at each rising edge
// Notes:   Mode register contents arrive as plain ports
// How it works
// R1: Read to precharge spacing kept by controller
// R2: Write to precharge waits WL+BL/2+tWR
// R3: Write-AP to precharge waits WL+BL/2+WR
// R4: Precharge to precharge at least one cycle
// R5: Controller rounds read-to-precharge cycles up
// R6: Precharge period from latest precharge per bank
// R7: All rows refreshed within 64 ms
// R8: CS RAS CAS low, WE high refreshes
// R9: Banks idle tRP before refresh command
// R10: Refresh uses internal row counter only
// R11: CKE low with NOP or deselect enters power-down
// R12: CKE kept high during MRS, read, write
// R13: Idle banks precharge power-down, else active
// R14: Controller holds CKE low minimum pulse
// R15: Power-down stay at most nine intervals
// R16: CKE high with NOP or deselect exits
// R17: DLL should be locked at power-down entry
// R18: Clock change only in precharge power-down
// R19: Stable clock and DLL reset after change
// R20: Decode strobes and CKE; A10 selects mode
// R21: Bank bits select bank or mode register
// R22: BL four bursts never interrupted
// R23: Self-refresh exit NOP only, read after 200
// R24: Self refresh entered only when idle
// R25: Controller tracks per-bank spacing timestamps; the model uses fixed NOP gaps per command instead
`timescale 1ns/1ps
`default_nettype none
module dpc_cmd_core (
	input  wire logic                         core_clk_i,
	input  wire logic                         reset_i,
	input  wire dpc_pkg::dpc_pins_s           pins_i,
	input  wire logic                         dll_fast_exit_i,
	output var dpc_pkg::dpc_dec_s             dec_o,
	output logic      [dpc_pkg::BANKS-1:0]    bank_open_o,
	output logic      [dpc_pkg::BANKS-1:0]    bank_ready_o,
	output logic      [2:0]                   power_state_o,
	output logic                              dll_on_o,
	output logic                              refresh_pulse_o,
	output logic      [dpc_pkg::ROW_W-1:0]    refresh_row_o,
	output logic      [dpc_pkg::BA_W-1:0]     mrs_select_o,
	output logic                              mrs_pulse_o,
	output logic      [dpc_pkg::ROW_W-1:0]    open_row_o,
	output logic                              cmd_ready_o
);

	// ==========================================================
	// Decode
	dpc_pkg::dpc_cmd_e           cmd_now;
	logic                        a10;
	logic                        cke_prev_reg;
	logic                        powered;
	dpc_pkg::dpc_pw_e            pw_reg;
	dpc_pkg::dpc_pw_e            pw_next;
	logic [dpc_pkg::CNT_W-1:0]   pre_cnt_reg [dpc_pkg::BANKS];
	logic [dpc_pkg::CNT_W-1:0]   xp_cnt_reg;
	logic                        nop_like;
	logic                        exec;

	// Strobes decoded into a command, A10 split out
	assign cmd_now  = dpc_pkg::dpc_decode(pins_i.cs_n, pins_i.ras_n, pins_i.cas_n, pins_i.we_n); // [R20]
	assign a10      = pins_i.addr[dpc_pkg::A10_POS]; // [R20]
	assign nop_like = (cmd_now == dpc_pkg::DPC_CMD_NOP) || (cmd_now == dpc_pkg::DPC_CMD_DESEL);
	assign powered  = (pw_reg == dpc_pkg::DPC_PW_UP);
	// Commands execute only with CKE high on both edges and no exit latency pending
	assign exec     = powered && cke_prev_reg && pins_i.cke && (xp_cnt_reg == '0); // [R16]
	assign cmd_ready_o = powered && (xp_cnt_reg == '0);

	// Registered decode output
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			dec_o <= '0;
		end else begin
			dec_o.valid     <= exec && !nop_like;
			dec_o.cmd       <= cmd_now;
			dec_o.auto_pre  <= a10 && (cmd_now == dpc_pkg::DPC_CMD_READ || cmd_now == dpc_pkg::DPC_CMD_WRITE); // [R20]
			dec_o.all_banks <= a10 && (cmd_now == dpc_pkg::DPC_CMD_PRE); // [R20]
			dec_o.bank      <= pins_i.ba; // [R21]
		end
	end

	// Previous CKE sample
	always_ff @(posedge core_clk_i) begin
		if (reset_i)
			cke_prev_reg <= 1'b0;
		else
			cke_prev_reg <= pins_i.cke;
	end

	// ==========================================================
	// Bank state and precharge period
	logic [dpc_pkg::BANKS-1:0] pre_hit;
	logic                      all_idle;

	// Banks hit by a precharge, one or all
	always_comb begin
		pre_hit = '0;
		if (exec && cmd_now == dpc_pkg::DPC_CMD_PRE) begin
			if (a10)
				pre_hit = '1;
			else
				pre_hit[pins_i.ba] = 1'b1; // [R21]
		end
	end

	// Open flags per bank
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			bank_open_o <= '0;
		end else begin
			for (int b = 0; b < dpc_pkg::BANKS; b++) begin
				if (pre_hit[b])
					bank_open_o[b] <= 1'b0;
				else if (exec && cmd_now == dpc_pkg::DPC_CMD_ACT && pins_i.ba == b[dpc_pkg::BA_W-1:0])
					bank_open_o[b] <= 1'b1;
			end
		end
	end

	// Precharge period restarts from the latest precharge to each bank
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			for (int b = 0; b < dpc_pkg::BANKS; b++)
				pre_cnt_reg[b] <= '0;
		end else begin
			for (int b = 0; b < dpc_pkg::BANKS; b++) begin
				if (pre_hit[b])
					pre_cnt_reg[b] <= a10 ? dpc_pkg::CNT_W'(dpc_pkg::TRP_ALL_CYC) : dpc_pkg::CNT_W'(dpc_pkg::TRP_CYC); // [R6]
				else if (pre_cnt_reg[b] != '0)
					pre_cnt_reg[b] <= pre_cnt_reg[b] - 1'b1;
			end
		end
	end

	// Ready means closed and precharge period done
	always_comb begin
		for (int b = 0; b < dpc_pkg::BANKS; b++)
			bank_ready_o[b] = !bank_open_o[b] && (pre_cnt_reg[b] == '0);
	end
	assign all_idle = (bank_ready_o == '1); // [R9]

	// ==========================================================
	// Open row memory
	dpc_row_mem u_row_mem (
		.core_clk_i (core_clk_i),
		.wr_en_i    (exec && cmd_now == dpc_pkg::DPC_CMD_ACT),
		.wr_bank_i  (pins_i.ba),
		.wr_row_i   (pins_i.addr),
		.rd_bank_i  (pins_i.ba),
		.rd_row_o   (open_row_o)
	);

	// ==========================================================
	// Refresh and mode register strobes
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			refresh_pulse_o <= 1'b0;
			refresh_row_o   <= '0;
		end else begin
			refresh_pulse_o <= exec && cmd_now == dpc_pkg::DPC_CMD_REF; // [R8]
			if (exec && cmd_now == dpc_pkg::DPC_CMD_REF)
				refresh_row_o <= refresh_row_o + 1'b1; // [R10]
		end
	end

	// Mode register select comes from the bank bits
	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			mrs_pulse_o  <= 1'b0;
			mrs_select_o <= '0;
		end else begin
			mrs_pulse_o <= exec && cmd_now == dpc_pkg::DPC_CMD_MRS;
			if (exec && cmd_now == dpc_pkg::DPC_CMD_MRS)
				mrs_select_o <= pins_i.ba; // [R21]
		end
	end

	// ==========================================================
	// Power state machine
	always_comb begin
		pw_next = pw_reg;
		case (pw_reg)
			dpc_pkg::DPC_PW_UP: begin
				if (cke_prev_reg && !pins_i.cke) begin
					if (nop_like)
						pw_next = (bank_open_o == '0) ? dpc_pkg::DPC_PW_PPD : dpc_pkg::DPC_PW_APD; // [R11] [R13]
					else if (cmd_now == dpc_pkg::DPC_CMD_REF && all_idle)
						pw_next = dpc_pkg::DPC_PW_SELF;
				end
			end
			dpc_pkg::DPC_PW_PPD,
			dpc_pkg::DPC_PW_APD,
			dpc_pkg::DPC_PW_SELF: begin
				if (pins_i.cke && nop_like)
					pw_next = dpc_pkg::DPC_PW_EXIT; // [R16]
			end
			dpc_pkg::DPC_PW_EXIT: pw_next = dpc_pkg::DPC_PW_UP;
			default:              pw_next = dpc_pkg::DPC_PW_UP;
		endcase
	end

	// State register
	always_ff @(posedge core_clk_i) begin
		if (reset_i)
			pw_reg <= dpc_pkg::DPC_PW_UP;
		else
			pw_reg <= pw_next;
	end
	assign power_state_o = pw_reg;

	// Exit latency before an executable command
	always_ff @(posedge core_clk_i) begin
		if (reset_i)
			xp_cnt_reg <= '0;
		else if (pw_reg == dpc_pkg::DPC_PW_EXIT)
			xp_cnt_reg <= dpc_pkg::CNT_W'(dpc_pkg::TXP_CYC - 1); // [R16]
		else if (xp_cnt_reg != '0)
			xp_cnt_reg <= xp_cnt_reg - 1'b1;
	end

	// DLL kept only in fast-exit active power-down
	always_ff @(posedge core_clk_i) begin
		if (reset_i)
			dll_on_o <= 1'b1;
		else
			dll_on_o <= (pw_next == dpc_pkg::DPC_PW_UP) || (pw_next == dpc_pkg::DPC_PW_EXIT) ||
				(pw_next == dpc_pkg::DPC_PW_APD && dll_fast_exit_i); // [R13]
	end

	// ==========================================================
	// Checks
	sequence s_pd_entry;
		cke_prev_reg && !pins_i.cke && nop_like && powered;
	endsequence

	a_ppd_entry_idle: assert property (@(posedge core_clk_i) disable iff (reset_i) // [R13]
		s_pd_entry and (bank_open_o == '0) |=> pw_reg == dpc_pkg::DPC_PW_PPD)
		else $error("Idle power-down did not enter precharge state");
	a_apd_entry_open: assert property (@(posedge core_clk_i) disable iff (reset_i) // [R11]
		s_pd_entry and (bank_open_o != '0) |=> pw_reg == dpc_pkg::DPC_PW_APD)
		else $error("Open-bank power-down did not enter active state");
	a_refresh_pulse: assert property (@(posedge core_clk_i) disable iff (reset_i) // [R8]
		exec && !pins_i.cs_n && !pins_i.ras_n && !pins_i.cas_n && pins_i.we_n |=> refresh_pulse_o)
		else $error("Refresh command not seen");
	a_refresh_row: assert property (@(posedge core_clk_i) disable iff (reset_i) // [R10]
		refresh_pulse_o |-> refresh_row_o == $past(refresh_row_o) + 1'b1)
		else $error("Refresh row counter did not advance");
	a_pd_exit_lat: assert property (@(posedge core_clk_i) disable iff (reset_i) // [R16]
		pw_reg == dpc_pkg::DPC_PW_EXIT |=> !exec ##1 cmd_ready_o)
		else $error("Exit latency wrong");
	a_pre_all_period: assert property (@(posedge core_clk_i) disable iff (reset_i) // [R6]
		exec && cmd_now == dpc_pkg::DPC_CMD_PRE && a10 |=> !bank_ready_o[0] [*2] ##1 bank_ready_o[0])
		else $error("All-bank precharge period wrong");
	a_dll_off_ppd: assert property (@(posedge core_clk_i) disable iff (reset_i) // [R13]
		pw_reg == dpc_pkg::DPC_PW_PPD |-> !dll_on_o)
		else $error("DLL on in precharge power-down");
	a_mrs_select: assert property (@(posedge core_clk_i) disable iff (reset_i) // [R21]
		exec && cmd_now == dpc_pkg::DPC_CMD_MRS |=> mrs_pulse_o && mrs_select_o == $past(pins_i.ba))
		else $error("Mode register select wrong");
	a_auto_pre_flag: assert property (@(posedge core_clk_i) disable iff (reset_i) // [R20]
		exec && cmd_now == dpc_pkg::DPC_CMD_READ |=> dec_o.auto_pre == $past(a10))
		else $error("Auto-precharge flag wrong");

endmodule // dpc_cmd_core
`default_nettype wire

// ==== dpc_ctl_model.sv ====
// Purpose: Behavioural memory-controller model driving the command pins
// Assumes: Burst and latency settings given as parameters
// Notes:   Each command stands one edge, then NOPs fill the gap
`timescale 1ns/1ps
`default_nettype none
module dpc_ctl_model #(
	parameter int AL  = 0,
	parameter int BL  = 4,
	parameter int read_to_precharge_cycles = 2,
	parameter int WL  = 2,
	parameter int TWR = 3
) (
	input  wire logic          core_clk_i,
	output var dpc_pkg::dpc_pins_s pins_o
);
	// ==========================================================
	// Spacing the controller keeps before a precharge and after it
	localparam int RD_PRE  = AL + BL / 2 +
		((read_to_precharge_cycles > 2) ? read_to_precharge_cycles : 2) - 2;
	localparam int WR_PRE  = WL + BL / 2 + TWR;
	localparam int PRE_GAP = dpc_pkg::TRP_ALL_CYC + 1;

	// Idle: deselected, clock enabled
	initial begin
		pins_o = '0;
		pins_o.cke = 1'b1;
		pins_o.cs_n = 1'b1;
	end

	// One command, then NOPs with cke held and address lines toggling
	task automatic send(input logic cke, input logic [3:0] s, input logic [2:0] ba,
		input logic [13:0] a, input int gap);
		@(posedge core_clk_i);
		pins_o <= {cke, s, ba, a};
		repeat (gap) begin
			@(posedge core_clk_i);
			pins_o <= {cke, 4'h7, ba, ~pins_o.addr};
		end
	endtask
endmodule // dpc_ctl_model
`default_nettype wire

// ==== tb_ddr2_precharge_refresh_powerdown_cmd.sv ====
// Purpose: Self-checking bench for the command decoder and power states
// Assumes: Controller model keeps all spacing; short power-down stays
// Notes:   Pulses are counted by a monitor and checked afterwards
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
	$display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end
module tb_ddr2_precharge_refresh_powerdown_cmd;
	logic               core_clk_i;
	logic               reset_i;
	logic               dll_fast_exit_i;
	dpc_pkg::dpc_pins_s pins;
	dpc_pkg::dpc_dec_s  dec;
	dpc_pkg::dpc_dec_s  last_dec;
	logic [7:0]         bank_open;
	logic [7:0]         bank_ready;
	logic [2:0]         pstate;
	logic [2:0]         mrs_sel;
	logic               dll_on;
	logic               ref_pulse;
	logic               mrs_pulse;
	logic               cmd_ready;
	logic [13:0]        ref_row;
	logic [13:0]        open_row;
	int                 bad_count;
	int                 comparisons;
	int                 ref_cnt;
	int                 mrs_cnt;

	dpc_ctl_model u_ctl (.core_clk_i(core_clk_i), .pins_o(pins));
	dpc_cmd_core u_dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .pins_i(pins),
		.dll_fast_exit_i(dll_fast_exit_i), .dec_o(dec), .bank_open_o(bank_open),
		.bank_ready_o(bank_ready), .power_state_o(pstate), .dll_on_o(dll_on),
		.refresh_pulse_o(ref_pulse), .refresh_row_o(ref_row), .mrs_select_o(mrs_sel),
		.mrs_pulse_o(mrs_pulse), .open_row_o(open_row), .cmd_ready_o(cmd_ready));

	// ==========================================================
	// Clock and pulse monitor
	initial begin
		core_clk_i = 1'b0;
		forever #12.5 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) begin
		if (dec.valid === 1'b1) last_dec <= dec;
		if (ref_pulse === 1'b1) ref_cnt++;
		if (mrs_pulse === 1'b1) mrs_cnt++;
	end

	task automatic tally_and_finish();
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Command through the model, then settle to the falling edge
	task automatic cmd(input logic cke, input logic [3:0] s, input logic [2:0] ba,
		input logic [13:0] a, input int gap);
		u_ctl.send(cke, s, ba, a, gap);
		@(negedge core_clk_i);
	endtask

	task automatic wait_st(input logic [2:0] s);
		for (int i = 0; i < 8 && pstate !== s; i++) @(negedge core_clk_i);
		if (pstate !== s) begin
			bad_count++;
			tally_and_finish();
		end
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_open_close();
		cmd(1, 4'h3, 3'h5, 14'h1a2b, 3);
		`CHK(last_dec.cmd, dpc_pkg::DPC_CMD_ACT)
		`CHK(bank_open, 8'h20)
		`CHK(open_row, 14'h1a2b)
		cmd(1, 4'h5, 3'h5, 14'h0400, u_ctl.RD_PRE);
		`CHK(last_dec.cmd, dpc_pkg::DPC_CMD_READ)
		`CHK(last_dec.auto_pre, 1'b1)
		cmd(1, 4'h2, 3'h0, 14'h0400, u_ctl.PRE_GAP);
		`CHK(last_dec.all_banks, 1'b1)
		`CHK(bank_open, 8'h00)
		`CHK(bank_ready, 8'hff)
		cmd(1, 4'h3, 3'h2, 14'h0111, 3);
		cmd(1, 4'h3, 3'h6, 14'h0222, 3);
		cmd(1, 4'h4, 3'h2, 14'h0000, u_ctl.WR_PRE);
		`CHK(last_dec.cmd, dpc_pkg::DPC_CMD_WRITE)
		`CHK(last_dec.auto_pre, 1'b0)
		cmd(1, 4'h2, 3'h2, 14'h0000, u_ctl.PRE_GAP);
		`CHK(last_dec.bank, 3'h2)
		`CHK(last_dec.all_banks, 1'b0)
		`CHK(bank_open, 8'h40)
		cmd(1, 4'h2, 3'h0, 14'h0400, u_ctl.PRE_GAP);
	endtask

	task automatic t_mrs_refresh();
		cmd(1, 4'h0, 3'h3, 14'h0000, 2);
		`CHK(mrs_sel, 3'h3)
		`CHK(mrs_cnt, 1)
		// Refreshes posted just before the short power-down stays below
		cmd(1, 4'h1, 3'h0, 14'h3fff, u_ctl.PRE_GAP);
		cmd(1, 4'h1, 3'h7, 14'h1234, u_ctl.PRE_GAP);
		`CHK(ref_cnt, 2)
		`CHK(ref_row, 14'h0002)
		// Reserved strobe pattern decodes as illegal
		cmd(1, 4'h6, 3'h0, 14'h0000, 2);
		`CHK(last_dec.cmd, dpc_pkg::DPC_CMD_ILL)
	endtask

	task automatic t_power();
		`CHK(dll_on, 1'b1)
		cmd(0, 4'h7, 3'h0, 14'h0000, dpc_pkg::TCKE_CYC);
		`CHK(pstate, 3'h1)
		`CHK(dll_on, 1'b0)
		cmd(0, 4'h3, 3'h1, 14'h0005, 2);
		`CHK(bank_open, 8'h00)
		u_ctl.send(1, 4'h7, 3'h0, 14'h0000, 0);
		wait_st(3'h6);
		wait_st(3'h0);
		`CHK(cmd_ready, 1'b0)
		@(negedge core_clk_i);
		`CHK(cmd_ready, 1'b1)
		// DLL reset by a mode register command after precharge power-down exit
		cmd(1, 4'h0, 3'h0, 14'h0100, 2);
		`CHK(mrs_cnt, 2)
		`CHK(mrs_sel, 3'h0)
		cmd(1, 4'h3, 3'h4, 14'h0333, 3);
		@(posedge core_clk_i);
		dll_fast_exit_i <= 1'b1;
		cmd(0, 4'h7, 3'h4, 14'h0000, dpc_pkg::TCKE_CYC);
		`CHK(pstate, 3'h3)
		`CHK(dll_on, 1'b1)
		cmd(1, 4'h7, 3'h4, 14'h0000, 6);
		@(posedge core_clk_i);
		dll_fast_exit_i <= 1'b0;
		cmd(0, 4'h7, 3'h4, 14'h0000, dpc_pkg::TCKE_CYC);
		`CHK(dll_on, 1'b0)
		cmd(1, 4'h7, 3'h4, 14'h0000, 6);
		`CHK(pstate, 3'h0)
		cmd(1, 4'h2, 3'h0, 14'h0400, u_ctl.PRE_GAP);
		cmd(0, 4'h1, 3'h0, 14'h0000, dpc_pkg::TCKE_CYC);
		`CHK(pstate, 3'h2)
		cmd(1, 4'h7, 3'h0, 14'h0000, 200);
		`CHK(pstate, 3'h0)
	endtask

	// Main sequence
	initial begin
		reset_i = 1'b1;
		dll_fast_exit_i = 1'b0;
		bad_count = 0;
		comparisons = 0;
		ref_cnt = 0;
		mrs_cnt = 0;
		last_dec = '0;
		repeat (6) @(posedge core_clk_i);
		reset_i <= 1'b0;
		repeat (2) @(negedge core_clk_i);
		`CHK(pstate, 3'h0)
		`CHK(dll_on, 1'b1)
		`CHK(cmd_ready, 1'b1)
		`CHK(ref_row, 14'h0000)
		t_open_close();
		t_mrs_refresh();
		t_power();
		tally_and_finish();
	end
endmodule // tb_ddr2_precharge_refresh_powerdown_cmd
`default_nettype wire
